// [ppp_pkg.sv]
// Shared constants and types of the parallel programming port.
// Assumes a single 125 MHz clock and pins already synchronous to it.
package ppp_pkg;

  // ----------------------------------------------------------------
  // Strobe actions and byte selects
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  localparam logic [1:0] BS_LOW = 2'h0;
  localparam logic [1:0] BS_HIGH = 2'h1;
  localparam logic [1:0] BS_EXT = 2'h2;
  localparam logic [1:0] BS_RSVD = 2'h3;

  localparam int ADDR_LOW_LSB = 0;
  localparam int ADDR_HIGH_LSB = 8;
  localparam int ADDR_EXT_LSB = 16;
  localparam int ADDR_W = 24;

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  // ----------------------------------------------------------------
  // Entry and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;
  localparam int MIN_LOAD_TOGGLES = 6;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ENTRY_GUARD_NS = 100;
  localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_FLASH_ERASE = 3'h1,
    OP_EE_ERASE = 3'h2,
    OP_LOCK_CLEAR = 3'h3,
    OP_FLASH_WORD = 3'h4,
    OP_EE_BYTE = 3'h5,
    OP_FUSE_WRITE = 3'h6,
    OP_LOCK_WRITE = 3'h7
  } nvm_op_t;

  typedef struct packed {
    logic valid;
    logic last;
    nvm_op_t op;
    logic [23:0] addr;
    logic [15:0] data;
  } nvm_req_t;

  localparam nvm_req_t REQ_IDLE = '{valid: 1'b0, last: 1'b0, op: OP_NONE,
                                    addr: 24'h000000, data: 16'h0000};

  typedef struct packed {
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] fuse_ext;
    logic [7:0] lock_bits;
  } fuse_view_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ER_FLASH = 6'h02,
    ST_ER_EE = 6'h04,
    ST_ER_LOCK = 6'h08,
    ST_STREAM = 6'h10,
    ST_WAIT = 6'h20
  } prog_state_t;

endpackage

// [strobe_edges.sv]
// Edge detector for a group of programming strobes.
// Assumes the strobes are already synchronous to mclk.
module strobe_edges #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] idle_level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_reg;

  // Reset low: no false fall, and a strobe already high at release still rises unless its idle_level bit is set
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  always_comb begin
    rise = level & ~prev_reg & ~idle_level;
    fall = ~level & prev_reg;
  end

endmodule // strobe_edges

// [prog_entry.sv]
// Programming mode entry detector.
// Assumes the high-voltage level on reset arrives as a logic input.
module prog_entry (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_pin_low,
  input wire logic hv_reset,
  input wire logic load_rise,
  input wire logic [3:0] entry_pins,
  output logic prog_mode
);

  logic [2:0] toggle_reg;
  logic hv_prev_reg;
  logic guard_reg;
  logic [7:0] guard_cnt_reg;

  // --------------------------------------------------------------
  // Load strobe toggles counted while reset is held low
  // --------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_reg <= 3'h0;
    end else if (!reset_pin_low && !hv_reset) begin
      toggle_reg <= 3'h0;
    end else if (reset_pin_low && load_rise && toggle_reg != 3'(ppp_pkg::MIN_LOAD_TOGGLES)) begin
      toggle_reg <= toggle_reg + 3'h1;
    end
  end

  // --------------------------------------------------------------
  // Guard window after high voltage; any pattern change aborts
  // --------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hv_prev_reg <= 1'b0;
      guard_reg <= 1'b0;
      guard_cnt_reg <= 8'h00;
      prog_mode <= 1'b0;
    end else begin
      hv_prev_reg <= hv_reset;
      if (!hv_reset) begin
        guard_reg <= 1'b0;
        prog_mode <= 1'b0;
      end else if (!hv_prev_reg) begin
        guard_reg <= (toggle_reg == 3'(ppp_pkg::MIN_LOAD_TOGGLES))
                     && (entry_pins == ppp_pkg::ENTRY_PATTERN);
        guard_cnt_reg <= 8'h00;
      end else if (guard_reg) begin
        if (entry_pins != ppp_pkg::ENTRY_PATTERN) begin
          guard_reg <= 1'b0;
        end else if (guard_cnt_reg == 8'(ppp_pkg::ENTRY_GUARD_CYC - 1)) begin
          guard_reg <= 1'b0;
          prog_mode <= 1'b1;
        end else begin
          guard_cnt_reg <= guard_cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule // prog_entry

// [parallel_program_port.sv]
// Parallel high-voltage programming port, device side.
// Assumes a memory controller answers each request group with nvm_done.
//
// Notes on behaviour
// - Load strobe action: address, data, command, idle
// - Write commands decoded, run on write strobe
// - Read commands decoded for signature, fuses, memories
// - Byte selects pick low, high, extended address
// - Low and high selects pick data byte; upper two reserved
// - Fuse read: low, lock, extended, high
// - Ready flag low while busy, high otherwise
// - Device drives data only while output strobe low
// - Pattern change in guard window blocks entry
// - Command and address held across operations
// - High address byte reloaded only per window
// - Erase flash, eeprom, then locks; fuses kept
// - Keep-eeprom fuse spares eeprom on erase
// - Erase: command, write strobe, wait for ready
// - Page latch stores data word at address
// - Low address bits pick word, upper pick page
// - Write strobe with select zero programs page
// - Command zero is no-op, ends page session
module parallel_program_port #(
  parameter int FLASH_PAGE_WORDS = 128,
  parameter int EE_PAGE_BYTES = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_pin_low,
  input wire logic hv_reset,
  input wire logic load_strobe_pin,
  input wire logic strobe_action_msb,
  input wire logic strobe_action_lsb,
  input wire logic byte_sel_msb,
  input wire logic byte_sel_lsb,
  input wire logic buffer_latch_strobe,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic prog_ready_flag,
  output logic prog_mode,
  input wire logic keep_eeprom_fuse,
  input wire ppp_pkg::fuse_view_t fuses,
  input wire logic [15:0] rd_word,
  output logic [23:0] rd_addr,
  output logic [7:0] rd_cmd,
  input wire logic nvm_done,
  output ppp_pkg::nvm_req_t nvm_req
);

  localparam int FW = $clog2(FLASH_PAGE_WORDS);
  localparam logic [23:0] FL_MASK = 24'(FLASH_PAGE_WORDS - 1);
  localparam logic [23:0] EE_MASK = 24'(EE_PAGE_BYTES - 1);

  // ----------------------------------------------------------------
  // Strobe edges and mode entry
  // ----------------------------------------------------------------
  logic [3:0] rise;
  logic [3:0] fall;
  logic load_ok;
  logic latch_ok;
  logic wr_ok;
  logic [1:0] action;
  logic [1:0] bsel;

  strobe_edges #(.W(4)) edges (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level({oe_n, wr_n, buffer_latch_strobe, load_strobe_pin}),
    .idle_level(4'hC),
    .rise(rise),
    .fall(fall)
  );

  prog_entry entry (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .reset_pin_low(reset_pin_low),
    .hv_reset(hv_reset),
    .load_rise(rise[0]),
    .entry_pins({buffer_latch_strobe, strobe_action_msb, strobe_action_lsb, byte_sel_lsb}),
    .prog_mode(prog_mode)
  );

  // Pins sampled on the same cycle the load edge is seen
  always_comb begin
    action = {strobe_action_msb, strobe_action_lsb};
    bsel = {byte_sel_msb, byte_sel_lsb};
    load_ok = prog_mode && rise[0];
    latch_ok = prog_mode && rise[1];
    wr_ok = prog_mode && fall[2];
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_ee(input logic [7:0] cmd);
    return cmd == ppp_pkg::CMD_WR_EE;
  endfunction

  function automatic logic [FW-1:0] word_index(input logic [7:0] cmd, input logic [23:0] a);
    logic [23:0] m;
    m = is_ee(cmd) ? EE_MASK : FL_MASK;
    return FW'(a & m);
  endfunction

  // Page bits from the held address, word bits from the stream index
  function automatic logic [23:0] page_addr(input logic [7:0] cmd, input logic [23:0] a,
                                            input logic [FW-1:0] idx);
    logic [23:0] m;
    m = is_ee(cmd) ? EE_MASK : FL_MASK;
    return (a & ~m) | (24'(idx) & m);
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [1:0] bs,
                                           input logic [15:0] w, input ppp_pkg::fuse_view_t f);
    logic [7:0] b;
    b = 8'h00;
    case (cmd)
      ppp_pkg::CMD_RD_FUSE: begin
        case (bs)
          ppp_pkg::BS_LOW: b = f.fuse_low;
          ppp_pkg::BS_HIGH: b = f.lock_bits;
          ppp_pkg::BS_EXT: b = f.fuse_ext;
          default: b = f.fuse_high;
        endcase
      end
      ppp_pkg::CMD_RD_FLASH, ppp_pkg::CMD_RD_SIG: begin
        if (!bs[1]) begin
          b = bs[0] ? w[15:8] : w[7:0];
        end
      end
      ppp_pkg::CMD_RD_EE: b = w[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Held command, address and data bytes
  // ----------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [23:0] addr_reg;
  logic [7:0] data_lo_reg;
  logic [7:0] data_hi_reg;
  logic session_reg;
  ppp_pkg::prog_state_t state_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= ppp_pkg::CMD_NOP;
    end else if (load_ok && action == ppp_pkg::ACT_CMD) begin
      cmd_reg <= data_in;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= 24'h000000;
    end else if (load_ok && action == ppp_pkg::ACT_ADDR) begin
      case (bsel)
        ppp_pkg::BS_LOW: addr_reg[ppp_pkg::ADDR_LOW_LSB +: 8] <= data_in;
        ppp_pkg::BS_HIGH: addr_reg[ppp_pkg::ADDR_HIGH_LSB +: 8] <= data_in;
        ppp_pkg::BS_EXT: addr_reg[ppp_pkg::ADDR_EXT_LSB +: 8] <= data_in;
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_lo_reg <= 8'h00;
      data_hi_reg <= 8'h00;
    end else if (load_ok && action == ppp_pkg::ACT_DATA && !byte_sel_msb) begin
      if (byte_sel_lsb) begin
        data_hi_reg <= data_in;
      end else begin
        data_lo_reg <= data_in;
      end
    end
  end

  // Page session: opened by a latch, closed by no-op or by any idle write strobe with low select
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      session_reg <= 1'b0;
    end else if (latch_ok) begin
      session_reg <= 1'b1;
    end else if (load_ok && action == ppp_pkg::ACT_CMD && data_in == ppp_pkg::CMD_NOP) begin
      session_reg <= 1'b0;
    end else if (wr_ok && state_reg == ppp_pkg::ST_IDLE && bsel == ppp_pkg::BS_LOW) begin
      session_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  // Plain storage, no reset: contents only matter after a latch
  logic [15:0] page_buf [FLASH_PAGE_WORDS];

  always_ff @(posedge mclk) begin
    if (latch_ok) begin
      page_buf[word_index(cmd_reg, addr_reg)] <= {data_hi_reg, data_lo_reg};
    end
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  logic [FW-1:0] idx_reg;
  logic flash_erased_reg;
  logic [FW-1:0] last_idx;

  always_comb begin
    last_idx = is_ee(cmd_reg) ? FW'(EE_PAGE_BYTES - 1) : FW'(FLASH_PAGE_WORDS - 1);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ppp_pkg::ST_IDLE;
      prog_ready_flag <= 1'b1;
      idx_reg <= '0;
      flash_erased_reg <= 1'b0;
      nvm_req <= ppp_pkg::REQ_IDLE;
    end else begin
      nvm_req <= ppp_pkg::REQ_IDLE;
      case (state_reg)
        ppp_pkg::ST_IDLE: begin
          flash_erased_reg <= 1'b0;
          if (wr_ok) begin
            case (cmd_reg)
              ppp_pkg::CMD_ERASE: begin
                nvm_req.valid <= 1'b1;
                nvm_req.op <= ppp_pkg::OP_FLASH_ERASE;
                state_reg <= ppp_pkg::ST_ER_FLASH;
                prog_ready_flag <= 1'b0;
              end
              ppp_pkg::CMD_WR_FLASH, ppp_pkg::CMD_WR_EE: begin
                if (bsel == ppp_pkg::BS_LOW) begin
                  idx_reg <= '0;
                  state_reg <= ppp_pkg::ST_STREAM;
                  prog_ready_flag <= 1'b0;
                end
              end
              ppp_pkg::CMD_WR_FUSE: begin
                if (bsel != ppp_pkg::BS_RSVD) begin
                  nvm_req.valid <= 1'b1;
                  nvm_req.op <= ppp_pkg::OP_FUSE_WRITE;
                  nvm_req.addr <= 24'(bsel);
                  nvm_req.data <= {8'h00, data_lo_reg};
                  state_reg <= ppp_pkg::ST_WAIT;
                  prog_ready_flag <= 1'b0;
                end
              end
              ppp_pkg::CMD_WR_LOCK: begin
                nvm_req.valid <= 1'b1;
                nvm_req.op <= ppp_pkg::OP_LOCK_WRITE;
                nvm_req.data <= {8'h00, data_lo_reg};
                state_reg <= ppp_pkg::ST_WAIT;
                prog_ready_flag <= 1'b0;
              end
              default: state_reg <= ppp_pkg::ST_IDLE;
            endcase
          end
        end
        ppp_pkg::ST_ER_FLASH: begin
          if (nvm_done) begin
            flash_erased_reg <= 1'b1;
            nvm_req.valid <= 1'b1;
            if (keep_eeprom_fuse) begin
              nvm_req.op <= ppp_pkg::OP_LOCK_CLEAR;
              state_reg <= ppp_pkg::ST_ER_LOCK;
            end else begin
              nvm_req.op <= ppp_pkg::OP_EE_ERASE;
              state_reg <= ppp_pkg::ST_ER_EE;
            end
          end
        end
        ppp_pkg::ST_ER_EE: begin
          if (nvm_done) begin
            nvm_req.valid <= 1'b1;
            nvm_req.op <= ppp_pkg::OP_LOCK_CLEAR;
            state_reg <= ppp_pkg::ST_ER_LOCK;
          end
        end
        ppp_pkg::ST_STREAM: begin
          nvm_req.valid <= 1'b1;
          nvm_req.op <= is_ee(cmd_reg) ? ppp_pkg::OP_EE_BYTE : ppp_pkg::OP_FLASH_WORD;
          nvm_req.addr <= page_addr(cmd_reg, addr_reg, idx_reg);
          nvm_req.data <= page_buf[idx_reg];
          nvm_req.last <= (idx_reg == last_idx);
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == last_idx) begin
            state_reg <= ppp_pkg::ST_WAIT;
          end
        end
        ppp_pkg::ST_ER_LOCK, ppp_pkg::ST_WAIT: begin
          if (nvm_done) begin
            state_reg <= ppp_pkg::ST_IDLE;
            prog_ready_flag <= 1'b1;
          end
        end
        default: begin
          state_reg <= ppp_pkg::ST_IDLE;
          prog_ready_flag <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path and bus direction
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      data_oe_n <= 1'b1;
      data_out <= 8'h00;
      rd_addr <= 24'h000000;
      rd_cmd <= ppp_pkg::CMD_NOP;
    end else begin
      data_oe_n <= oe_n || !prog_mode;
      data_out <= read_byte(cmd_reg, bsel, rd_word, fuses);
      rd_addr <= addr_reg;
      rd_cmd <= cmd_reg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_ready_state: assert property (prog_ready_flag == (state_reg == ppp_pkg::ST_IDLE))
    else $error("ready flag disagrees with sequencer state");
  a_cmd_load: assert property (load_ok && action == ppp_pkg::ACT_CMD
    |=> cmd_reg == $past(data_in))
    else $error("command byte not captured");
  a_addr_low: assert property (load_ok && action == ppp_pkg::ACT_ADDR
    && bsel == ppp_pkg::BS_LOW |=> addr_reg[7:0] == $past(data_in) && $stable(addr_reg[23:8]))
    else $error("address low byte not captured alone");
  a_addr_ext: assert property (load_ok && action == ppp_pkg::ACT_ADDR
    && bsel == ppp_pkg::BS_EXT |=> addr_reg[23:16] == $past(data_in))
    else $error("address extended byte not captured");
  a_idle_hold: assert property (load_ok && action == ppp_pkg::ACT_IDLE && !latch_ok
    |=> $stable(cmd_reg) && $stable(addr_reg) && $stable(data_lo_reg) && $stable(data_hi_reg))
    else $error("idle action changed held bytes");
  a_bus_drive: assert property (oe_n |=> data_oe_n)
    else $error("bus driven with output strobe high");
  a_erase_start: assert property (wr_ok && state_reg == ppp_pkg::ST_IDLE
    && cmd_reg == ppp_pkg::CMD_ERASE |=> !prog_ready_flag && nvm_req.valid
    && nvm_req.op == ppp_pkg::OP_FLASH_ERASE)
    else $error("erase did not start");
  a_lock_order: assert property (nvm_req.valid && nvm_req.op == ppp_pkg::OP_LOCK_CLEAR
    |-> flash_erased_reg)
    else $error("locks cleared before flash erase finished");
  a_keep_ee: assert property (nvm_req.valid && nvm_req.op == ppp_pkg::OP_EE_ERASE
    |-> !keep_eeprom_fuse)
    else $error("eeprom erased although kept");
  a_fuse_read: assert property (cmd_reg == ppp_pkg::CMD_RD_FUSE
    && bsel == ppp_pkg::BS_HIGH && $stable(cmd_reg) |=> data_out == $past(fuses.lock_bits))
    else $error("lock byte not presented");
  a_nop_ends: assert property (load_ok && action == ppp_pkg::ACT_CMD
    && data_in == ppp_pkg::CMD_NOP && !latch_ok |=> !session_reg)
    else $error("no-op did not end page session");
  a_page_len: assert property ($rose(state_reg == ppp_pkg::ST_STREAM)
    && !is_ee(cmd_reg) |-> (state_reg == ppp_pkg::ST_STREAM) [*8])
    else $error("page stream ended early");

  c_erase_done: cover property (state_reg == ppp_pkg::ST_ER_LOCK && nvm_done);
  c_page_write: cover property (nvm_req.valid && nvm_req.last);
  c_fuse_read: cover property (!data_oe_n && cmd_reg == ppp_pkg::CMD_RD_FUSE);

endmodule // parallel_program_port

// [nvm_model.sv]
// Memory partner: takes nvm_req groups, answers nvm_done, serves rd_word.
// Assumes one valid pulse per word and one answer per group.
module nvm_model (
  input wire logic mclk,
  input wire logic slow,
  input wire ppp_pkg::nvm_req_t nvm_req,
  input wire logic [23:0] rd_addr,
  output logic [15:0] rd_word,
  output logic nvm_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mem [256];
  ppp_pkg::nvm_req_t seen [$];
  int cnt = 0;
  initial begin
    nvm_done = 1'b0;
    // Blank words read as a pattern, so a stale zero never matches
    foreach (mem[i]) mem[i] = 16'hA5C3 ^ 16'(i);
  end
  assign rd_word = mem[rd_addr[7:0]];
  always @(posedge mclk) begin
    nvm_done <= (cnt == 1);
    if (cnt > 0) cnt <= cnt - 1;
    if (nvm_req.valid) begin
      seen.push_back(nvm_req);
      if (nvm_req.op == ppp_pkg::OP_FLASH_ERASE) foreach (mem[i]) mem[i] <= 16'hFFFF;
      if (nvm_req.op == ppp_pkg::OP_FLASH_WORD) mem[nvm_req.addr[7:0]] <= nvm_req.data;
      // Slow answers keep ready low well past the write strobe
      if (nvm_req.op != ppp_pkg::OP_FLASH_WORD || nvm_req.last) cnt <= slow ? 40 : 2;
    end
  end
endmodule // nvm_model

// [parallel_program_port_tb_top.sv]
// Self-checking bench of the programming port with a reference memory.
// Assumes nvm_model stands behind the memory handshake.
module parallel_program_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PW = 32;
  localparam int PG = 8;
  logic mclk = 1'b0, sys_rst = 1'b1, reset_pin_low = 1'b0, hv_reset = 1'b0;
  logic load_strobe_pin = 1'b0, strobe_action_msb = 1'b1, strobe_action_lsb = 1'b1;
  logic byte_sel_msb = 1'b0, byte_sel_lsb = 1'b0, buffer_latch_strobe = 1'b0;
  logic wr_n = 1'b1, oe_n = 1'b1, keep_eeprom_fuse = 1'b0, slow = 1'b1;
  logic nvm_done, data_oe_n, prog_ready_flag, prog_mode;
  logic [7:0] data_in = 8'h00, data_out, rd_cmd, rnd = 8'h52;
  logic [15:0] rd_word;
  logic [23:0] rd_addr;
  logic [15:0] exp_mem [256];
  ppp_pkg::fuse_view_t fuses = 32'hE299_FDFC;
  ppp_pkg::nvm_req_t nvm_req;
  int error_cnt = 0, checks = 0;
  parallel_program_port #(.FLASH_PAGE_WORDS(PG), .EE_PAGE_BYTES(4)) uut (.mclk, .sys_rst,
    .reset_pin_low, .hv_reset, .load_strobe_pin, .strobe_action_msb, .strobe_action_lsb,
    .byte_sel_msb, .byte_sel_lsb, .buffer_latch_strobe, .wr_n, .oe_n, .data_in, .data_out,
    .data_oe_n, .prog_ready_flag, .prog_mode, .keep_eeprom_fuse, .fuses, .rd_word, .rd_addr,
    .rd_cmd, .nvm_done, .nvm_req);
  nvm_model mdl (.mclk, .slow, .nvm_req, .rd_addr, .rd_word, .nvm_done);
  initial forever #4 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lfsr();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(PW);
    s = 1'b0;
    tick(PW);
  endtask
  task automatic load(logic [1:0] act, logic [1:0] bs, logic [7:0] d);
    {strobe_action_msb, strobe_action_lsb} = act;
    {byte_sel_msb, byte_sel_lsb} = bs;
    data_in = d;
    tick(9);
    pulse(load_strobe_pin);
  endtask
  task automatic strobe_wr();
    wr_n = 1'b0;
    tick(3);
    chk(16'(prog_ready_flag), 16'h0000);
    tick(PW);
    wr_n = 1'b1;
    tick(2);
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 3000 && prog_ready_flag !== 1'b1; i++) tick(1);
    if (prog_ready_flag !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: ready flag timeout", $time);
      conclude();
    end
  endtask
  task automatic rd(logic [1:0] bs, logic [7:0] exp);
    {byte_sel_msb, byte_sel_lsb} = bs;
    oe_n = 1'b0;
    data_in = ~data_in;
    tick(3);
    chk(16'(data_oe_n), 16'h0000);
    chk(16'(data_out), 16'(exp));
    oe_n = 1'b1;
    tick(3);
    chk(16'(data_oe_n), 16'h0001);
  endtask
  task automatic enter(logic glitch);
    hv_reset = 1'b0;
    reset_pin_low = 1'b1;
    {buffer_latch_strobe, strobe_action_msb, strobe_action_lsb, byte_sel_lsb} = 4'h0;
    repeat (6) pulse(load_strobe_pin);
    tick(13);
    reset_pin_low = 1'b0;
    hv_reset = 1'b1;
    tick(5);
    byte_sel_lsb = glitch;
    tick(40);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [15:0] w;
    foreach (exp_mem[k]) exp_mem[k] = 16'hFFFF;
    tick(4);
    sys_rst = 1'b0;
    enter(1'b1);
    chk(16'(prog_mode), 16'h0000);
    enter(1'b0);
    chk(16'(prog_mode), 16'h0001);
    tick(6250);
    for (i = 0; i < 2; i++) begin
      keep_eeprom_fuse = i[0];
      mdl.seen.delete();
      load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_ERASE);
      strobe_wr();
      wait_ready();
      chk(16'(mdl.seen.size()), 16'(3 - i));
      chk(16'(mdl.seen[0].op), 16'(ppp_pkg::OP_FLASH_ERASE));
      chk(16'(mdl.seen[$].op), 16'(ppp_pkg::OP_LOCK_CLEAR));
    end
    slow = 1'b0;
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_WR_FLASH);
    for (i = 0; i < PG; i++) begin
      w = {lfsr(), lfsr()};
      exp_mem[8'h18 + i] = w;
      load(ppp_pkg::ACT_ADDR, ppp_pkg::BS_LOW, 8'(8'h18 + i));
      load(ppp_pkg::ACT_DATA, 2'h0, w[7:0]);
      load(ppp_pkg::ACT_DATA, 2'h1, w[15:8]);
      load(ppp_pkg::ACT_IDLE, 2'h1, 8'h00);
      byte_sel_lsb = 1'b1;
      pulse(buffer_latch_strobe);
    end
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_NOP);
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_WR_FLASH);
    load(ppp_pkg::ACT_ADDR, ppp_pkg::BS_HIGH, 8'h00);
    load(ppp_pkg::ACT_ADDR, ppp_pkg::BS_EXT, 8'h00);
    {byte_sel_msb, byte_sel_lsb} = ppp_pkg::BS_LOW;
    mdl.seen.delete();
    strobe_wr();
    wait_ready();
    chk(16'(mdl.seen.size()), 16'(PG));
    chk(16'(mdl.seen[$].last), 16'h0001);
    w = {8'h00, lfsr()};
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_WR_FUSE);
    load(ppp_pkg::ACT_DATA, ppp_pkg::BS_LOW, w[7:0]);
    {byte_sel_msb, byte_sel_lsb} = ppp_pkg::BS_EXT;
    mdl.seen.delete();
    strobe_wr();
    wait_ready();
    chk(16'(mdl.seen[0].op), 16'(ppp_pkg::OP_FUSE_WRITE));
    chk(mdl.seen[0].data, w);
    chk(16'(mdl.seen[0].addr), 16'(ppp_pkg::BS_EXT));
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_RD_FLASH);
    for (i = 0; i <= PG; i++) begin
      load(ppp_pkg::ACT_ADDR, ppp_pkg::BS_LOW, 8'(8'h18 + i));
      rd(2'h0, exp_mem[8'h18 + i][7:0]);
      rd(2'h1, exp_mem[8'h18 + i][15:8]);
    end
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_RD_FUSE);
    rd(2'h0, fuses.fuse_low);
    rd(2'h1, fuses.lock_bits);
    rd(2'h2, fuses.fuse_ext);
    rd(2'h3, fuses.fuse_high);
    load(ppp_pkg::ACT_ADDR, ppp_pkg::BS_LOW, 8'h1A);
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_RD_SIG);
    rd(2'h1, exp_mem[8'h1A][15:8]);
    load(ppp_pkg::ACT_CMD, ppp_pkg::BS_LOW, ppp_pkg::CMD_RD_EE);
    chk(16'(rd_cmd), 16'(ppp_pkg::CMD_RD_EE));
    rd(2'h0, exp_mem[8'h1A][7:0]);
    conclude();
  end
endmodule // parallel_program_port_tb_top
